/* src/iofs_map.svh */
`ifndef IOFS_MAP_SVH
`define IOFS_MAP_SVH

// Register addresses on the special-function register bus.
`define IOFS_ADDR_PORT2     8'ha0
`define IOFS_ADDR_LOCATION  8'hf1
`define IOFS_ADDR_ANALOG    8'hf2
`define IOFS_ADDR_P0SELECT  8'hf3
`define IOFS_ADDR_P1SELECT  8'hf4
`define IOFS_ADDR_P2SELECT  8'hf5
`define IOFS_ADDR_PORT0_DIR 8'hfd
`define IOFS_ADDR_PORT1_DIR 8'hfe
`define IOFS_ADDR_P2PRIO    8'hff

// Reset values.
`define IOFS_RST_PORT2      8'hff
`define IOFS_RST_ZERO       8'h00
`define IOFS_RST_PRIO       2'b00

// Writable bit masks; other bits read zero.
`define IOFS_MASK_LOCATION  8'h73
`define IOFS_MASK_P2SELECT  8'h7f

// Field positions in the location register.
`define IOFS_LOC_TIMER_ONE    6
`define IOFS_LOC_TIMER_THREE  5
`define IOFS_LOC_TIMER_FOUR   4
`define IOFS_LOC_SERIAL_ONE   1
`define IOFS_LOC_SERIAL_ZERO  0

// Field positions in the port 2 select register.
`define IOFS_P2S_SERIALS      6
`define IOFS_P2S_S1_T3        5
`define IOFS_P2S_T1_T4        4
`define IOFS_P2S_S0_T1        3
`define IOFS_P2S_PIN4         2
`define IOFS_P2S_PIN3         1
`define IOFS_P2S_PIN0         0

// Priority field position in the port 2 direction register.
`define IOFS_PRIO_HI          7
`define IOFS_PRIO_LO          6

`endif

/* src/iofs_pkg.sv */
package iofs_pkg;

  // Port 0 shared-pin priority encodings.
  typedef enum logic [1:0] {
    IOFS_PRI_S0_OVER_S1 = 2'b00,
    IOFS_PRI_S1_OVER_S0 = 2'b01,
    IOFS_PRI_T1_OVER_S1 = 2'b10,
    IOFS_PRI_T1C2_OVER_S0 = 2'b11
  } iofs_prio_e;

  // Register bus request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
  } iofs_req_s;

  // Pin control for one eight-bit port.
  typedef struct packed {
    logic [7:0] periph;
    logic [7:0] dir_out;
    logic [7:0] analog;
  } iofs_port_s;

  // Winners of the port 1 and port 0 shared-pin arbitration.
  typedef struct packed {
    logic serial_zero_wins_serial_one;
    logic serial_one_wins_timer_three;
    logic timer_one_wins_timer_four;
    logic serial_zero_wins_timer_one;
    logic p0_serial_one_wins_serial_zero;
    logic p0_timer_one_wins_serial_one;
    logic p0_timer_one_wins_serial_zero;
  } iofs_grant_s;

endpackage : iofs_pkg

/* src/iofs_arbiter.sv */
`timescale 1ns/1ps
`include "iofs_map.svh"

// Turns the priority bits into registered winners for shared pins.
module iofs_arbiter
  import iofs_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Priority settings.
  input  wire logic [7:0]  port2_select,
  input  wire logic [1:0]  p0_prio,
  // Registered decisions.
  output iofs_grant_s      grant
);

  iofs_grant_s next_grant;
  iofs_prio_e  prio;

  // Decode both priority sets each cycle.
  always_comb begin
    prio = iofs_prio_e'(p0_prio);
    next_grant.serial_zero_wins_serial_one =
      !port2_select[`IOFS_P2S_SERIALS];
    next_grant.serial_one_wins_timer_three =
      !port2_select[`IOFS_P2S_S1_T3];
    next_grant.timer_one_wins_timer_four =
      !port2_select[`IOFS_P2S_T1_T4];
    next_grant.serial_zero_wins_timer_one =
      !port2_select[`IOFS_P2S_S0_T1];
    next_grant.p0_serial_one_wins_serial_zero =
      (prio == IOFS_PRI_S1_OVER_S0);
    next_grant.p0_timer_one_wins_serial_one =
      (prio == IOFS_PRI_T1_OVER_S1);
    next_grant.p0_timer_one_wins_serial_zero =
      (prio == IOFS_PRI_T1C2_OVER_S0);
  end

  // Decisions are registered one edge after the inputs change, the same edge that loads the settings.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      grant <= '{default: 1'b0, serial_zero_wins_serial_one: 1'b1,
                 serial_one_wins_timer_three: 1'b1,
                 timer_one_wins_timer_four: 1'b1,
                 serial_zero_wins_timer_one: 1'b1};
    end else begin
      grant <= next_grant;
    end
  end

endmodule : iofs_arbiter

/* src/iofs_top.sv */
`timescale 1ns/1ps
`include "iofs_map.svh"

module iofs_top
  import iofs_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Register bus.
  input  iofs_req_s        req,
  output logic [7:0]       rdata,
  // Port 0 and port 1 pin control.
  output iofs_port_s       port0,
  output logic [7:0]       port1_periph,
  output logic [7:0]       port1_dir_out,
  // Port 2 value and pin selection.
  output logic [4:0]       third_port_values,
  output logic             third_port_pin4_function,
  output logic             third_port_pin3_function,
  output logic             third_port_pin0_function,
  // Peripheral locations, one means alternative two.
  output logic             timer_one_location,
  output logic             timer_three_location,
  output logic             timer_four_location,
  output logic             serial_one_location,
  output logic             serial_zero_location,
  // Shared-pin winners.
  output iofs_grant_s      grant
);

  // Stored register contents.
  logic [7:0] port2;
  logic [7:0] location;
  logic [7:0] analog;
  logic [7:0] p0_select;
  logic [7:0] p1_select;
  logic [7:0] port2_select;
  logic [7:0] p0_dir;
  logic [7:0] p1_dir;
  logic [1:0] p0_prio;
  // Values the registers and pins take at the next edge.
  logic [7:0] next_port2;
  logic [7:0] next_location;
  logic [7:0] next_analog;
  logic [7:0] next_p0_select;
  logic [7:0] next_p1_select;
  logic [7:0] next_port2_select;
  logic [7:0] next_p0_dir;
  logic [7:0] next_p1_dir;
  logic [1:0] next_p0_prio;
  logic [7:0] next_rdata;
  logic [7:0] next_p0_periph;

  // True when a full-byte write targets the given address.
  function automatic logic hit(input iofs_req_s r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // Register writes; reserved bits are masked so they stay zero and a
  // later read cannot mistake them for stored state.
  always_comb begin
    next_port2     = port2;
    next_location  = location;
    next_analog    = analog;
    next_p0_select = p0_select;
    next_p1_select = p1_select;
    next_port2_select = port2_select;
    next_p0_dir    = p0_dir;
    next_p1_dir    = p1_dir;
    next_p0_prio   = p0_prio;
    if (hit(req, `IOFS_ADDR_PORT2)) begin
      next_port2 = req.wdata;
    end
    // The bit write comes after the byte write, so it wins for its bit.
    if (req.bit_wr && req.addr == `IOFS_ADDR_PORT2) begin
      next_port2[req.bit_sel] = req.bit_val;
    end
    if (hit(req, `IOFS_ADDR_LOCATION)) begin
      next_location = req.wdata & `IOFS_MASK_LOCATION;
    end
    if (hit(req, `IOFS_ADDR_ANALOG)) begin
      next_analog = req.wdata;
    end
    if (hit(req, `IOFS_ADDR_P0SELECT)) begin
      next_p0_select = req.wdata;
    end
    if (hit(req, `IOFS_ADDR_P1SELECT)) begin
      next_p1_select = req.wdata;
    end
    if (hit(req, `IOFS_ADDR_P2SELECT)) begin
      next_port2_select = req.wdata & `IOFS_MASK_P2SELECT;
    end
    if (hit(req, `IOFS_ADDR_PORT0_DIR)) begin
      next_p0_dir = req.wdata;
    end
    if (hit(req, `IOFS_ADDR_PORT1_DIR)) begin
      next_p1_dir = req.wdata;
    end
    if (hit(req, `IOFS_ADDR_P2PRIO)) begin
      next_p0_prio = req.wdata[`IOFS_PRIO_HI:`IOFS_PRIO_LO];
    end
  end

  // Read mux; unmapped addresses return zero.
  // Reads have no side effects, so a stray read never disturbs a pin.
  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `IOFS_ADDR_PORT2:    next_rdata = port2;
        `IOFS_ADDR_LOCATION: next_rdata = location;
        `IOFS_ADDR_ANALOG:   next_rdata = analog;
        `IOFS_ADDR_P0SELECT: next_rdata = p0_select;
        `IOFS_ADDR_P1SELECT: next_rdata = p1_select;
        `IOFS_ADDR_P2SELECT: next_rdata = port2_select;
        `IOFS_ADDR_PORT0_DIR: next_rdata = p0_dir;
        `IOFS_ADDR_PORT1_DIR: next_rdata = p1_dir;
        `IOFS_ADDR_P2PRIO:   next_rdata = {p0_prio, 6'h00};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  // Register state.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      port2     <= `IOFS_RST_PORT2;
      location  <= `IOFS_RST_ZERO;
      analog    <= `IOFS_RST_ZERO;
      p0_select <= `IOFS_RST_ZERO;
      p1_select <= `IOFS_RST_ZERO;
      port2_select <= `IOFS_RST_ZERO;
      p0_dir    <= `IOFS_RST_ZERO;
      p1_dir    <= `IOFS_RST_ZERO;
      p0_prio   <= `IOFS_RST_PRIO;
      rdata     <= 8'h00;
    end else begin
      port2     <= next_port2;
      location  <= next_location;
      analog    <= next_analog;
      p0_select <= next_p0_select;
      p1_select <= next_p1_select;
      port2_select <= next_port2_select;
      p0_dir    <= next_p0_dir;
      p1_dir    <= next_p1_dir;
      p0_prio   <= next_p0_prio;
      rdata     <= next_rdata;
    end
  end

  // Analog use takes a port 0 pin away from its peripheral, so the two
  // can never both claim the same pin.
  always_comb begin
    next_p0_periph = next_p0_select & ~next_analog;
  end

  // Pin outputs are registered from the next values, so they track the
  // registers without an extra cycle of lag.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      port0             <= '0;
      port1_periph      <= 8'h00;
      port1_dir_out     <= 8'h00;
      third_port_values <= 5'h1f;
      third_port_pin4_function <= 1'b0;
      third_port_pin3_function <= 1'b0;
      third_port_pin0_function <= 1'b0;
    end else begin
      port0.analog  <= next_analog;
      port0.periph  <= next_p0_periph;
      port0.dir_out <= next_p0_dir;
      port1_periph  <= next_p1_select;
      port1_dir_out <= next_p1_dir;
      third_port_values <= next_port2[4:0];
      third_port_pin4_function <= next_port2_select[`IOFS_P2S_PIN4];
      third_port_pin3_function <= next_port2_select[`IOFS_P2S_PIN3];
      third_port_pin0_function <= next_port2_select[`IOFS_P2S_PIN0];
    end
  end

  // Location outputs sit in a stage of their own; they change rarely and
  // every peripheral's pin mux reads them.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      timer_one_location   <= 1'b0;
      timer_three_location <= 1'b0;
      timer_four_location  <= 1'b0;
      serial_one_location  <= 1'b0;
      serial_zero_location <= 1'b0;
    end else begin
      timer_one_location   <= next_location[`IOFS_LOC_TIMER_ONE];
      timer_three_location <= next_location[`IOFS_LOC_TIMER_THREE];
      timer_four_location  <= next_location[`IOFS_LOC_TIMER_FOUR];
      serial_one_location  <= next_location[`IOFS_LOC_SERIAL_ONE];
      serial_zero_location <= next_location[`IOFS_LOC_SERIAL_ZERO];
    end
  end

  // Arbitration sees the next values so grants line up with the pins.
  // Feeding it the registers instead would leave the grants a cycle late.
  iofs_arbiter u_arbiter (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .port2_select (next_port2_select),
    .p0_prio      (next_p0_prio),
    .grant        (grant)
  );

endmodule : iofs_top

/* dv/iofs_pin_model.sv */
`timescale 1ns/1ps

// Pins left to plain output drive once analog and peripheral use are
// removed; an analog pin never drives even if its direction says output.
module iofs_pin_model
  import iofs_pkg::*;
(
  // Pin control from the block.
  input  iofs_port_s  port0,
  // Resolved drive.
  output logic [7:0]  p0_drive
);
  // Analog and peripheral ownership both mask the output drive.
  assign p0_drive = port0.dir_out & ~port0.analog & ~port0.periph;
endmodule : iofs_pin_model

/* dv/iofs_top_assertions.sv */
`timescale 1ns/1ps
`include "iofs_map.svh"

// Checks register writes against the pin and grant outputs.
module iofs_top_assertions
  import iofs_pkg::*;
(
  // Clock and reset.
  input  wire logic   mclk,
  input  wire logic   rst_b,
  // Observed ports.
  input  iofs_req_s   req,
  input  logic [7:0]  rdata,
  input  iofs_port_s  port0,
  input  logic [7:0]  port1_periph,
  input  logic [4:0]  third_port_values,
  input  logic        timer_one_location,
  input  iofs_grant_s grant
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_analog_wins: assert property (
    (port0.periph & port0.analog) == 8'h00) else $error("analog overlap");
  a_analog_write: assert property (
    req.wr && req.addr == `IOFS_ADDR_ANALOG |=>
    port0.analog == $past(req.wdata)) else $error("analog write lost");
  a_p1_select: assert property (
    req.wr && req.addr == `IOFS_ADDR_P1SELECT |=>
    port1_periph == $past(req.wdata)) else $error("port1 select lost");
  a_timer_loc: assert property (
    req.wr && req.addr == `IOFS_ADDR_LOCATION |=>
    timer_one_location == $past(req.wdata[6])) else $error("location");
  a_serials_grant: assert property (
    req.wr && req.addr == `IOFS_ADDR_P2SELECT |=>
    grant.serial_zero_wins_serial_one != $past(req.wdata[6]))
    else $error("serial grant wrong");
  a_reserved_zero: assert property (
    req.rd && req.addr == `IOFS_ADDR_LOCATION |=>
    rdata[7] == 1'b0 && rdata[3:2] == 2'b00) else $error("reserved set");
  a_port2_bit_write: assert property (
    req.bit_wr && req.addr == `IOFS_ADDR_PORT2 && req.bit_sel < 3'h5 |=>
    third_port_values[$past(req.bit_sel)] == $past(req.bit_val))
    else $error("port2 bit write lost");
  a_port2_holds: assert property (
    !req.wr && !req.bit_wr |=> $stable(third_port_values))
    else $error("port2 value moved");
endmodule : iofs_top_assertions

bind iofs_top iofs_top_assertions u_chk (.mclk(mclk), .rst_b(rst_b),
  .req(req), .rdata(rdata), .port0(port0), .port1_periph(port1_periph),
  .third_port_values(third_port_values),
  .timer_one_location(timer_one_location), .grant(grant));

/* dv/io_port_function_select_bench.sv */
`timescale 1ns/1ps
`include "iofs_map.svh"

module io_port_function_select_bench;
  import iofs_pkg::*;
  logic        mclk, rst_b;
  iofs_req_s   req;
  iofs_port_s  port0;
  iofs_grant_s grant;
  logic [7:0]  rdata, p1_periph, p1_dir, p0_drive;
  logic [4:0]  p2v;
  wire  [4:0]  loc;
  logic        p4f, p3f, p0f;
  int          error_cnt = 0, n_compared = 0;
  localparam logic [7:0] ADR [9] = '{8'ha0, 8'hf1, 8'hf2, 8'hf3, 8'hf4,
                                     8'hf5, 8'hfd, 8'hfe, 8'hff};
  localparam logic [7:0] EXF [9] = '{8'hff, 8'h73, 8'hff, 8'hff, 8'hff,
                                     8'h7f, 8'hff, 8'hff, 8'hc0};

  iofs_top dut (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .port0(port0), .port1_periph(p1_periph), .port1_dir_out(p1_dir),
    .third_port_values(p2v), .third_port_pin4_function(p4f),
    .third_port_pin3_function(p3f), .third_port_pin0_function(p0f),
    .timer_one_location(loc[4]), .timer_three_location(loc[3]),
    .timer_four_location(loc[2]), .serial_one_location(loc[1]),
    .serial_zero_location(loc[0]), .grant(grant));
  iofs_pin_model u_pins (.port0(port0), .p0_drive(p0_drive));

  // Free-running clock at 50 MHz.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One request held for one edge, then released at the taking edge.
  task automatic op(input iofs_req_s r);
    @(posedge mclk) req <= r;
    @(posedge mclk) req <= '0;
    #1;
  endtask : op

  task automatic wr(input logic [7:0] a, d);
    op('{1'b1, 1'b0, a, d, 1'b0, 3'h0, 1'b0});
  endtask : wr

  task automatic rd(input logic [7:0] a, exp);
    op('{1'b0, 1'b1, a, 8'h00, 1'b0, 3'h0, 1'b0});
    chk("rdata", rdata, exp);
  endtask : rd

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well beyond the hundred or so cycles the tests need.
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    req   = '0;
    rst_b = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk("p2v", {3'h0, p2v}, 8'h1f);
    chk("loc", {3'h0, loc}, 8'h00);
    chk("grant", {1'b0, grant}, 8'h78);
    for (int i = 0; i < 9; i++) rd(ADR[i], {8{i == 0}});
    for (int i = 0; i < 9; i++) wr(ADR[i], 8'hff);
    for (int i = 0; i < 9; i++) rd(ADR[i], EXF[i]);
    chk("loc", {3'h0, loc}, 8'h1f);
    wr(8'hf1, 8'h12);
    chk("loc", {3'h0, loc}, 8'h06);
    // Analog bit 4 overlaps select bit 4, so precedence is really exercised.
    wr(8'hf3, 8'h30);
    wr(8'hf2, 8'h1f);
    wr(8'hfd, 8'h5a);
    chk("p0_analog", port0.analog, 8'h1f);
    chk("p0_periph", port0.periph, 8'h20);
    chk("p0_dir", port0.dir_out, 8'h5a);
    chk("p0_drive", p0_drive, 8'h40);
    wr(8'hfe, 8'ha5);
    wr(8'hf4, 8'h3c);
    chk("p1_dir", p1_dir, 8'ha5);
    chk("p1_periph", p1_periph, 8'h3c);
    wr(8'hf5, 8'h05);
    chk("p2_fn", {5'h0, p4f, p3f, p0f}, 8'h05);
    // Each port 1 priority bit alone flips only its own winner.
    wr(8'hf5, 8'h08);
    chk("grant_p1", {4'h0, grant[6:3]}, 8'h0e);
    wr(8'hf5, 8'h10);
    chk("grant_p1", {4'h0, grant[6:3]}, 8'h0d);
    wr(8'hf5, 8'h20);
    chk("grant_p1", {4'h0, grant[6:3]}, 8'h0b);
    wr(8'hf5, 8'h40);
    chk("grant_p1", {4'h0, grant[6:3]}, 8'h07);
    for (int p = 0; p < 4; p++) begin
      wr(8'hff, 8'(p << 6));
      chk("grant_p0", 8'(grant[2:0]), p == 0 ? 8'h00 : 8'h08 >> p);
      rd(8'hff, 8'(p << 6));
    end
    wr(8'ha0, 8'h00);
    op('{1'b0, 1'b0, 8'ha0, 8'h00, 1'b1, 3'h3, 1'b1});
    chk("p2v", {3'h0, p2v}, 8'h08);
    rd(8'ha0, 8'h08);
    rd(8'h10, 8'h00);
    // A second reset in mid-run must restore the defaults.
    @(posedge mclk) rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk("p2v", {3'h0, p2v}, 8'h1f);
    chk("loc", {3'h0, loc}, 8'h00);
    chk("grant", {1'b0, grant}, 8'h78);
    rd(8'hf2, 8'h00);
    report_and_stop();
  end
endmodule : io_port_function_select_bench
